//--- verilog/accel_regs_pkg.sv
// Package with the register map, field masks, defaults and carrier types of the accelerometer register space.
package accel_regs_pkg;

    localparam int REG_W = 8;
    localparam int NUM_REGS = 64;
    localparam int ADDR_W = 6;

    typedef logic [NUM_REGS-1:0][REG_W-1:0] reg_image_t;
    typedef logic [ADDR_W-1:0] reg_addr_t;
    typedef logic [REG_W-1:0] reg_byte_t;

    // Address map.
    localparam reg_addr_t ADDR_CHIP_ID = 6'h00;
    localparam reg_addr_t ADDR_RO_FIRST = 6'h01;
    localparam reg_addr_t ADDR_RO_LAST = 6'h0E;
    localparam reg_addr_t ADDR_WR_FIRST = 6'h0F;
    localparam reg_addr_t ADDR_SOFT_RESET = 6'h14;
    localparam reg_addr_t ADDR_IRQ_PIN_ELECTRICAL_CFG = 6'h20;
    localparam reg_addr_t ADDR_IRQ_LATCH_AND_CLEAR = 6'h21;
    localparam reg_addr_t ADDR_RESERVED_31 = 6'h31;
    localparam reg_addr_t ADDR_NONVOLATILE_CTRL = 6'h33;
    localparam reg_addr_t ADDR_OFFSET_COMP_CTRL = 6'h36;
    localparam reg_addr_t ADDR_USER_SCRATCH_0 = 6'h3B;
    localparam reg_addr_t ADDR_WR_LAST = 6'h3E;
    localparam reg_addr_t ADDR_QUEUE_READ_PORT = 6'h3F;

    // Key that starts a soft reset, and trigger bit positions.
    localparam reg_byte_t SOFT_RESET_KEY = 8'hB6;
    localparam int IRQ_CLEAR_BIT = 7;
    localparam int OFFSET_RESET_BIT = 7;
    localparam int CAL_TRIGGER_LSB = 5;
    localparam int NVM_LOAD_BIT = 3;

    // Identification code; the value is arbitrary.
    localparam reg_byte_t CHIP_ID_DEFAULT = 8'h5A;

    localparam reg_byte_t READ_ZERO = 8'h00;

    // Values after power-on or soft reset; read-only slots hold zero.
    localparam reg_image_t REG_DEFAULT = '{
        6'h0F: 8'h03, 6'h10: 8'h0F, 6'h15: 8'hFF, 6'h1C: 8'hFF, 6'h1D: 8'hFF, 6'h1F: 8'hFF,
        6'h20: 8'h05, 6'h22: 8'h09, 6'h23: 8'h30, 6'h24: 8'h81, 6'h25: 8'h0F, 6'h26: 8'hC0,
        6'h28: 8'h14, 6'h29: 8'h14, 6'h2A: 8'h04, 6'h2B: 8'h0A, 6'h2C: 8'h18, 6'h2D: 8'h48,
        6'h2E: 8'h08, 6'h2F: 8'h11, 6'h31: 8'hFF, 6'h33: 8'hF0, 6'h36: 8'h10, 6'h3D: 8'hFF,
        default: 8'h00
    };

    // Bits that a host write may change; reserved, trigger and status bits are zero here.
    localparam reg_image_t REG_WMASK = '{
        6'h0F: 8'h0F, 6'h10: 8'h1F, 6'h11: 8'hFE, 6'h12: 8'h60, 6'h13: 8'hC0, 6'h16: 8'hF7,
        6'h17: 8'h7F, 6'h18: 8'h0F, 6'h19: 8'hFF, 6'h1A: 8'hE7, 6'h1B: 8'hFF, 6'h1E: 8'h3F,
        6'h20: 8'h0F, 6'h21: 8'h0F, 6'h22: 8'hFF, 6'h23: 8'hFF, 6'h24: 8'hC7, 6'h25: 8'hFF,
        6'h26: 8'hFF, 6'h27: 8'hFF, 6'h28: 8'hFF, 6'h29: 8'hFF, 6'h2A: 8'hC7, 6'h2B: 8'hDF,
        6'h2C: 8'h7F, 6'h2D: 8'h7F, 6'h2E: 8'h3F, 6'h2F: 8'h37, 6'h30: 8'h3F, 6'h32: 8'h17,
        6'h33: 8'h01, 6'h34: 8'h07, 6'h36: 8'h07, 6'h37: 8'h7F, 6'h38: 8'hFF, 6'h39: 8'hFF,
        6'h3A: 8'hFF, 6'h3B: 8'hFF, 6'h3C: 8'hFF, 6'h3E: 8'hC3,
        default: 8'h00
    };

    // One host access, presented for one cycle.
    typedef struct packed {
        logic wr;
        logic rd;
        reg_addr_t addr;
        reg_byte_t wdata;
    } host_req_s;

    // One-cycle pulses that start internal sequences.
    typedef struct packed {
        logic soft_reset;
        logic irq_clear;
        logic offset_reset;
        logic [1:0] cal_trigger;
        logic nvm_load;
        logic fifo_pop;
    } trigger_s;

endpackage

//--- verilog/cfg_byte.sv
// One stored configuration byte with write mask and default value.
module cfg_byte #(
    parameter accel_regs_pkg::reg_byte_t DEFAULT = 8'h00,
    parameter accel_regs_pkg::reg_byte_t WMASK = 8'hFF
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Restore and write.
    input wire logic restore_i,
    input wire logic wr_i,
    input wire accel_regs_pkg::reg_byte_t wdata_i,
    // Stored value.
    output accel_regs_pkg::reg_byte_t q_o
);
    import accel_regs_pkg::*;

    typedef struct packed {
        reg_byte_t q;
    } cell_state_s;

    cell_state_s state_r;
    cell_state_s state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (restore_i) begin
            state_nxt.q = DEFAULT;
        end else if (wr_i) begin
            // Bits outside the mask keep their value whatever the host sends.
            state_nxt.q = (state_r.q & ~WMASK) | (wdata_i & WMASK);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r <= '{q: DEFAULT};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign q_o = state_r.q;

endmodule

//--- verilog/accel_register_space.sv
// Accelerometer register space: decode, storage, read mux and trigger pulses.
//
// Behaviour
// - Every register location holds exactly eight bits.
// - One flat space of 64 byte addresses, 0x00 to 0x3F, is decoded.
// - Writes to reserved bit positions are discarded and change no state.
// - Addresses 0x00 to 0x0E are read-only and writes to them are ignored.
// - Sequence-start bits, such as the interrupt clear at 0x21 and the soft reset at 0x14, are write-only.
// - Write-only trigger bits and registers read as zero.
// - Writing 0xB6 to the soft-reset register restores every default of the stored registers one cycle later.
module accel_register_space #(
    parameter accel_regs_pkg::reg_byte_t CHIP_ID = accel_regs_pkg::CHIP_ID_DEFAULT
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Host register access.
    input wire accel_regs_pkg::host_req_s host_req_i,
    output accel_regs_pkg::reg_byte_t rdata_o,
    output logic rvalid_o,
    // Status from the sensing engines.
    input wire accel_regs_pkg::reg_image_t status_i,
    input wire accel_regs_pkg::reg_byte_t fifo_byte_i,
    // Configuration and sequence triggers toward the engines.
    output accel_regs_pkg::reg_image_t cfg_o,
    output accel_regs_pkg::trigger_s trig_o
);
    import accel_regs_pkg::*;

    typedef struct packed {
        reg_byte_t rdata;
        logic rvalid;
        trigger_s trig;
    } top_state_s;

    top_state_s state_r;
    top_state_s state_nxt;
    reg_image_t stored;
    logic restore;

    // Selects what the host sees at one address.
    function automatic reg_byte_t read_value(input reg_addr_t addr, input reg_image_t img,
                                            input reg_image_t st, input reg_byte_t fifo_b);
        reg_byte_t v;
        v = img[addr];
        if (addr == ADDR_CHIP_ID) begin
            v = CHIP_ID;
        end else if (addr <= ADDR_RO_LAST) begin
            v = st[addr];
        end else if (addr == ADDR_SOFT_RESET) begin
            v = READ_ZERO;
        end else if (addr == ADDR_QUEUE_READ_PORT) begin
            v = fifo_b;
        end
        return v;
    endfunction

    function automatic logic write_to(input host_req_s req, input reg_addr_t addr);
        return req.wr && (req.addr == addr);
    endfunction

    // True where a configuration cell holds the byte.
    function automatic logic is_stored(input reg_addr_t addr);
        return (addr >= ADDR_WR_FIRST) && (addr <= ADDR_WR_LAST);
    endfunction

    // True where the byte comes from the sensing engines' status.
    function automatic logic is_status(input reg_addr_t addr);
        return (addr >= ADDR_RO_FIRST) && (addr <= ADDR_RO_LAST);
    endfunction

    // Soft reset acts one cycle after the key is written and wins over any write in that cycle.
    assign restore = state_r.trig.soft_reset;

    // Low read-only range and the queue port hold no storage.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_cell
            if (gi >= ADDR_WR_FIRST && gi <= ADDR_WR_LAST) begin : g_rw
                cfg_byte #(
                    .DEFAULT(REG_DEFAULT[gi]),
                    .WMASK(REG_WMASK[gi])
                ) u_cell (
                    .ref_clk_i(ref_clk_i),
                    .srst_i(srst_i),
                    .restore_i(restore),
                    .wr_i(write_to(host_req_i, reg_addr_t'(gi))),
                    .wdata_i(host_req_i.wdata),
                    .q_o(stored[gi])
                );
            end else begin : g_ro
                assign stored[gi] = READ_ZERO;
            end
        end
    endgenerate

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = host_req_i.rd;
        state_nxt.trig = '0;
        if (host_req_i.rd) begin
            state_nxt.rdata = read_value(host_req_i.addr, stored, status_i, fifo_byte_i);
            state_nxt.trig.fifo_pop = (host_req_i.addr == ADDR_QUEUE_READ_PORT);
        end
        if (host_req_i.wr) begin
            state_nxt.trig.soft_reset = write_to(host_req_i, ADDR_SOFT_RESET) &&
                                        (host_req_i.wdata == SOFT_RESET_KEY);
            state_nxt.trig.irq_clear = write_to(host_req_i, ADDR_IRQ_LATCH_AND_CLEAR) &&
                                       host_req_i.wdata[IRQ_CLEAR_BIT];
            state_nxt.trig.offset_reset = write_to(host_req_i, ADDR_OFFSET_COMP_CTRL) &&
                                          host_req_i.wdata[OFFSET_RESET_BIT];
            state_nxt.trig.cal_trigger = write_to(host_req_i, ADDR_OFFSET_COMP_CTRL) ?
                host_req_i.wdata[CAL_TRIGGER_LSB +: 2] : 2'b00;
            state_nxt.trig.nvm_load = write_to(host_req_i, ADDR_NONVOLATILE_CTRL) &&
                                      host_req_i.wdata[NVM_LOAD_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata_o = state_r.rdata;
    assign rvalid_o = state_r.rvalid;
    assign trig_o = state_r.trig;
    assign cfg_o = stored;

    // Checks.

    sequence s_key_written;
        host_req_i.wr && host_req_i.addr == ADDR_SOFT_RESET && host_req_i.wdata == SOFT_RESET_KEY;
    endsequence

    sequence s_restore_done;
        trig_o.soft_reset ##1 (cfg_o == REG_DEFAULT);
    endsequence

    chk_soft_reset_restore: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        s_key_written |=> s_restore_done)
    else $error("Soft reset key did not restore the defaults.");

    chk_wrong_key_no_restore: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.wr && host_req_i.addr == ADDR_SOFT_RESET && host_req_i.wdata != SOFT_RESET_KEY
         && !trig_o.soft_reset) |=> !trig_o.soft_reset)
    else $error("Soft reset started without the key.");

    chk_reset_defaults: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        $fell(srst_i) |-> (cfg_o == REG_DEFAULT))
    else $error("Registers did not hold their defaults after reset.");

    chk_ro_write_ignored: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.wr && host_req_i.addr <= ADDR_RO_LAST && !restore) |=> $stable(cfg_o))
    else $error("A write to the read-only range changed the register image.");

    chk_reserved_ignored: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.wr && host_req_i.addr == ADDR_IRQ_LATCH_AND_CLEAR && !restore)
        |=> ((cfg_o[ADDR_IRQ_LATCH_AND_CLEAR] & ~REG_WMASK[ADDR_IRQ_LATCH_AND_CLEAR])
             == ($past(cfg_o[ADDR_IRQ_LATCH_AND_CLEAR]) & ~REG_WMASK[ADDR_IRQ_LATCH_AND_CLEAR])))
    else $error("A write to reserved bits changed their content.");

    chk_full_byte_store: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.wr && host_req_i.addr == ADDR_USER_SCRATCH_0 && !restore)
        |=> (cfg_o[ADDR_USER_SCRATCH_0] == $past(host_req_i.wdata)))
    else $error("A full byte written to scratch did not read back whole.");

    chk_read_answer: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        host_req_i.rd |=> rvalid_o ##1 (rvalid_o == $past(host_req_i.rd)))
    else $error("A read was not answered in the next cycle.");

    chk_wo_reads_zero: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && (host_req_i.addr == ADDR_SOFT_RESET || host_req_i.addr == ADDR_IRQ_LATCH_AND_CLEAR))
        |=> !rdata_o[IRQ_CLEAR_BIT] && ($past(host_req_i.addr) != ADDR_SOFT_RESET || rdata_o == READ_ZERO))
    else $error("A write-only trigger bit read back non-zero.");

    sequence s_clear_written;
        host_req_i.wr && host_req_i.addr == ADDR_IRQ_LATCH_AND_CLEAR && host_req_i.wdata[IRQ_CLEAR_BIT];
    endsequence

    // A second clear in the following cycle legally stretches the pulse, so only a lone clear is judged.
    chk_irq_clear_pulse: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        s_clear_written ##1 !(host_req_i.wr && host_req_i.addr == ADDR_IRQ_LATCH_AND_CLEAR
                             && host_req_i.wdata[IRQ_CLEAR_BIT])
        |-> trig_o.irq_clear ##1 !trig_o.irq_clear)
    else $error("Interrupt clear did not give a single pulse.");

    chk_clear_bit_not_kept: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.wr && host_req_i.addr == ADDR_IRQ_LATCH_AND_CLEAR && host_req_i.wdata[IRQ_CLEAR_BIT])
        |=> !cfg_o[ADDR_IRQ_LATCH_AND_CLEAR][IRQ_CLEAR_BIT])
    else $error("The interrupt clear bit was stored.");

    // Writes reach only the writable bits of stored cells.
    sequence s_cell_written;
        host_req_i.wr && is_stored(host_req_i.addr) && !restore;
    endsequence

    sequence s_offset_written;
        host_req_i.wr && host_req_i.addr == ADDR_OFFSET_COMP_CTRL;
    endsequence

    chk_masked_bits_kept: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        s_cell_written |=> ((cfg_o[$past(host_req_i.addr)] & ~REG_WMASK[$past(host_req_i.addr)])
            == ($past(cfg_o[host_req_i.addr]) & ~REG_WMASK[$past(host_req_i.addr)])))
    else $error("A write changed a bit that the host may not write.");

    chk_unmasked_bits_taken: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        s_cell_written |=> ((cfg_o[$past(host_req_i.addr)] & REG_WMASK[$past(host_req_i.addr)])
            == ($past(host_req_i.wdata) & REG_WMASK[$past(host_req_i.addr)])))
    else $error("A write did not store its writable bits.");

    // Trigger pulses follow their writes by one cycle and need a write.
    chk_offset_reset_pulse: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        s_offset_written |=> (trig_o.offset_reset == $past(host_req_i.wdata[OFFSET_RESET_BIT])))
    else $error("Offset reset pulse did not follow its write.");

    chk_cal_trigger_pulse: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        s_offset_written |=> (trig_o.cal_trigger == $past(host_req_i.wdata[CAL_TRIGGER_LSB +: 2])))
    else $error("Calibration trigger did not follow its write.");

    chk_nvm_load_pulse: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.wr && host_req_i.addr == ADDR_NONVOLATILE_CTRL && host_req_i.wdata[NVM_LOAD_BIT])
        |=> trig_o.nvm_load)
    else $error("Memory load pulse did not follow its write.");

    chk_no_write_no_trigger: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !host_req_i.wr |=> !(trig_o.soft_reset || trig_o.irq_clear || trig_o.offset_reset || trig_o.nvm_load)
                           && (trig_o.cal_trigger == 2'b00))
    else $error("A sequence trigger pulsed without a write.");

    chk_key_starts_reset: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        trig_o.soft_reset |-> $past(host_req_i.wr && host_req_i.addr == ADDR_SOFT_RESET
                                    && host_req_i.wdata == SOFT_RESET_KEY))
    else $error("Soft reset pulsed without the key.");

    // Read answers by address range.
    chk_chip_id_read: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && host_req_i.addr == ADDR_CHIP_ID) |=> (rdata_o == CHIP_ID))
    else $error("Identification read returned a wrong byte.");

    chk_status_read: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && is_status(host_req_i.addr)) |=> (rdata_o == $past(status_i[host_req_i.addr])))
    else $error("Status read did not return the engine status.");

    chk_stored_read: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && is_stored(host_req_i.addr)) |=> (rdata_o == $past(cfg_o[host_req_i.addr])))
    else $error("Configuration read did not return the stored byte.");

    chk_queue_read: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && host_req_i.addr == ADDR_QUEUE_READ_PORT)
        |=> (rdata_o == $past(fifo_byte_i)) && trig_o.fifo_pop)
    else $error("Queue port read did not return and pop the queue byte.");

    chk_pop_needs_read: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        trig_o.fifo_pop |-> $past(host_req_i.rd && host_req_i.addr == ADDR_QUEUE_READ_PORT))
    else $error("Queue pop pulsed without a read of the queue port.");

    chk_read_idle: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !host_req_i.rd |=> !rvalid_o && $stable(rdata_o))
    else $error("Read answer moved without a read.");

    chk_reset_outputs: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        $fell(srst_i) |-> !rvalid_o && (trig_o == '0))
    else $error("Host outputs were not idle after reset.");

    chk_cal_bits_read_zero: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && host_req_i.addr == ADDR_OFFSET_COMP_CTRL)
        |=> !rdata_o[OFFSET_RESET_BIT] && (rdata_o[CAL_TRIGGER_LSB +: 2] == 2'b00))
    else $error("Offset trigger bits read back non-zero.");

    chk_load_bit_reads_zero: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        (host_req_i.rd && host_req_i.addr == ADDR_NONVOLATILE_CTRL) |=> !rdata_o[NVM_LOAD_BIT])
    else $error("Memory load bit read back non-zero.");

endmodule

//--- test/host_model.sv
// Host model that issues single register accesses on the block's host port.
module host_model (
    // Clock.
    input wire logic ref_clk_i,
    // Host access.
    output accel_regs_pkg::host_req_s req_o,
    input wire accel_regs_pkg::reg_byte_t rdata_i,
    input wire logic rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import accel_regs_pkg::*;

    logic timed_out;

    initial begin
        req_o = '0;
        timed_out = 1'b0;
    end

    // Launch after a falling edge, hold through the taking edge, release, then leave one idle cycle.
    // The whole byte is handed back; the caller decides which bits it relies on.
    task automatic access(input logic wr, input logic rd, input reg_addr_t a, input reg_byte_t d,
                          output reg_byte_t q);
        int n;
        req_o = '{wr: wr, rd: rd, addr: a, wdata: d};
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = '0;
        if (rd) begin
            for (n = 0; n < 4 && rvalid_i !== 1'b1; n++) begin
                @(negedge ref_clk_i);
            end
            if (n == 4) begin
                timed_out = 1'b1;
            end
            q = rdata_i;
        end
        @(negedge ref_clk_i);
    endtask
endmodule

//--- test/tb_top.sv
// Self-checking testbench of the accelerometer register space.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import accel_regs_pkg::*;

    logic ref_clk_i;
    logic srst_i;
    logic clr_seen;
    host_req_s req;
    reg_byte_t rdata;
    logic rvalid;
    reg_image_t status;
    reg_image_t cfg;
    reg_image_t img;
    reg_byte_t fifo_b;
    reg_byte_t q;
    reg_byte_t d;
    reg_addr_t a;
    trigger_s trig;
    trigger_s trig_seen;
    int n_errors;
    int n_tests;
    reg_addr_t tg_a [5] = '{6'h21, 6'h36, 6'h36, 6'h33, 6'h3F};
    reg_byte_t tg_d [5] = '{8'h80, 8'h80, 8'h60, 8'h08, 8'h00};
    trigger_s tg_e [5] = '{7'h20, 7'h10, 7'h0C, 7'h02, 7'h01};

    accel_register_space #(.CHIP_ID(CHIP_ID_DEFAULT)) dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .host_req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .status_i(status), .fifo_byte_i(fifo_b),
        .cfg_o(cfg), .trig_o(trig));
    host_model u_host (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // Gathers every trigger pulse since the last clear, so one-cycle pulses cannot slip past.
    always @(posedge ref_clk_i) begin
        trig_seen <= clr_seen ? '0 : (trig_seen | trig);
    end

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic rd(input reg_addr_t ad, output reg_byte_t qq);
        u_host.access(1'b0, 1'b1, ad, 8'h00, qq);
        if (u_host.timed_out) begin
            n_errors++;
            report_and_stop();
        end
    endtask

    task automatic wr(input reg_addr_t ad, input reg_byte_t dd);
        reg_byte_t dummy;
        u_host.access(1'b1, 1'b0, ad, dd, dummy);
        img[ad] = (img[ad] & ~REG_WMASK[ad]) | (dd & REG_WMASK[ad]);
    endtask

    function automatic reg_byte_t exp_read(input int ad);
        if (ad == 0) return CHIP_ID_DEFAULT;
        if (ad <= 14) return status[ad];
        if (ad == 63) return fifo_b;
        return img[ad];
    endfunction

    task automatic clear_seen;
        clr_seen = 1'b1;
        @(negedge ref_clk_i);
        clr_seen = 1'b0;
    endtask

    task automatic check_image(input string what);
        for (int i = 0; i < NUM_REGS; i++) begin
            check(what, cfg[i], img[i]);
        end
    endtask

    initial begin
        n_errors = 0;
        n_tests = 0;
        srst_i = 1'b1;
        clr_seen = 1'b0;
        void'($urandom(58));
        for (int i = 0; i < NUM_REGS; i++) begin
            status[i] = 8'($urandom);
        end
        fifo_b = 8'($urandom);
        img = REG_DEFAULT;
        repeat (20) @(negedge ref_clk_i);
        srst_i = 1'b0;
        check_image("reset image");
        for (int i = 0; i < NUM_REGS; i++) begin
            rd(6'(i), q);
            check("reset read", q, exp_read(i));
        end
        for (int i = 0; i < 15; i++) begin
            wr(6'(i), ~status[i]);
            check("ro cell", cfg[i], 8'h00);
            rd(6'(i), q);
            check("ro read", q, exp_read(i));
        end
        for (int k = 0; k < 200; k++) begin
            a = 6'(15 + $urandom_range(47));
            if (a == ADDR_RESERVED_31 || a == 6'h35 || a == 6'h3D) continue;
            d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
            if (a == ADDR_SOFT_RESET && d == SOFT_RESET_KEY) d = 8'hB5;
            wr(a, d);
            rd(a, q);
            check("rw read", q, exp_read(a));
        end
        for (int i = 0; i < 5; i++) begin
            clear_seen();
            if (i == 4) rd(tg_a[i], q);
            else wr(tg_a[i], tg_d[i]);
            repeat (2) @(negedge ref_clk_i);
            check("trigger", {1'b0, trig_seen}, {1'b0, tg_e[i]});
            rd(tg_a[i], q);
            check("trigger read", q, exp_read(tg_a[i]));
        end
        wr(ADDR_USER_SCRATCH_0, 8'h5C);
        clear_seen();
        wr(ADDR_SOFT_RESET, 8'hB5);
        repeat (2) @(negedge ref_clk_i);
        check("wrong key", {1'b0, trig_seen}, 8'h00);
        check_image("wrong key image");
        wr(ADDR_SOFT_RESET, SOFT_RESET_KEY);
        repeat (2) @(negedge ref_clk_i);
        check("soft reset", {1'b0, trig_seen}, 8'h40);
        img = REG_DEFAULT;
        check_image("soft reset image");
        rd(ADDR_SOFT_RESET, q);
        check("soft reset read", q, 8'h00);
        report_and_stop();
    end
endmodule
